// *** core/dacc_top.sv ***
/*
 * Control logic of a two-channel eight-bit converter: code, control and
 * standby registers on Avalon-MM, conversion enables, settle timers and
 * pin direction. Assumes standby indications synchronous to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none

module dacc_top #(
	parameter int unsigned CONV_CYC = dacc_pkg::CONV_CYCLES
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic soft_standby_i,
	input wire logic hard_standby_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [dacc_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [7:0] analog_out_ch0_o,
	output logic [7:0] analog_out_ch1_o,
	output logic [1:0] pin_oe_o,
	output logic [1:0] convert_run_o,
	output logic [1:0] pending_o
);
	import dacc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} dacc_bus_t;

	typedef struct packed {
		dacc_bus_t bus;
		logic [31:0] rdata;
		logic [1:0][7:0] code;
		logic [2:0] ctl;
		logic retain;
		logic soft_d;
		logic [1:0] run;
		logic [1:0][CNT_W-1:0] cnt;
		logic [1:0] pend;
		logic [1:0][7:0] level;
		logic [1:0] oe;
	} dacc_state_t;

	dacc_state_t st_ff;
	dacc_state_t nxt_st;

	function automatic logic [31:0] dacc_read(input dacc_state_t s, input logic [ADDR_W-1:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			OFS_CODE_CH0: r = {24'h00_0000, s.code[0]};
			OFS_CODE_CH1: r = {24'h00_0000, s.code[1]};
			OFS_CONTROL: r = {24'h00_0000, s.ctl, CONTROL_RSVD_ONES[4:0]};
			OFS_STANDBY_CTRL: r = {24'h00_0000, STANDBY_RSVD_ONES[7:1], s.retain};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	logic [1:0] en_own;
	logic [1:0] run_req;
	logic standby_entry;
	logic keep_regs;
	logic do_wr;
	logic [1:0] code_wr;

	always_comb begin
		nxt_st = st_ff;
		// write taken in the cycle waitrequest is low, i.e. the ack cycle
		do_wr = (st_ff.bus == BUS_ACK) && avs_write_i && avs_byteenable_i[0];
		code_wr = 2'b00;
		unique case (st_ff.bus)
			BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					nxt_st.bus = BUS_ACK;
					nxt_st.rdata = dacc_read(st_ff, avs_address_i);
				end
			end
			BUS_ACK: begin
				nxt_st.bus = BUS_IDLE;
			end
		endcase
		if (do_wr) begin
			unique case (avs_address_i)
				OFS_CODE_CH0: begin
					nxt_st.code[0] = avs_writedata_i[7:0];
					code_wr[0] = 1'b1;
				end
				OFS_CODE_CH1: begin
					nxt_st.code[1] = avs_writedata_i[7:0];
					code_wr[1] = 1'b1;
				end
				OFS_CONTROL: nxt_st.ctl = avs_writedata_i[7:5];
				OFS_STANDBY_CTRL: nxt_st.retain = avs_writedata_i[BIT_RETAIN_EN];
				default: nxt_st.ctl = nxt_st.ctl;
			endcase
		end
		// standby entry: hardware standby always, software unless retained
		nxt_st.soft_d = soft_standby_i;
		standby_entry = soft_standby_i && !st_ff.soft_d;
		keep_regs = st_ff.retain;
		if (hard_standby_i || (standby_entry && !keep_regs)) begin
			nxt_st.code[0] = RST_CODE;
			nxt_st.code[1] = RST_CODE;
			nxt_st.ctl = RST_CONTROL[7:5];
		end
		if (hard_standby_i) begin
			nxt_st.retain = RST_STANDBY_CTRL[BIT_RETAIN_EN];
		end
		// enables from the next-state control so pins follow in one cycle
		en_own[1] = nxt_st.ctl[BIT_OUT_EN_CH1 - 5];
		en_own[0] = nxt_st.ctl[BIT_OUT_EN_CH0 - 5];
		if (soft_standby_i && !st_ff.retain) begin
			en_own = 2'b00;
		end
		if (hard_standby_i) begin
			en_own = 2'b00;
		end
		if (en_own == 2'b00) begin
			run_req = 2'b00;
		end else if (nxt_st.ctl[BIT_JOINT_EN - 5]) begin
			run_req = 2'b11;
		end else begin
			run_req = en_own;
		end
		nxt_st.run = run_req;
		// separate settle timer per channel
		for (int i = 0; i < 2; i++) begin
			if (!run_req[i]) begin
				nxt_st.pend[i] = 1'b0;
				nxt_st.cnt[i] = '0;
			end else if ((run_req[i] && !st_ff.run[i]) || code_wr[i]
				|| (nxt_st.code[i] != st_ff.code[i])) begin
				nxt_st.pend[i] = 1'b1;
				nxt_st.cnt[i] = CNT_W'(CONV_CYC - 1);
			end else if (st_ff.pend[i]) begin
				if (st_ff.cnt[i] == '0) begin
					nxt_st.pend[i] = 1'b0;
					nxt_st.level[i] = st_ff.code[i];
				end else begin
					nxt_st.cnt[i] = st_ff.cnt[i] - 1'b1;
				end
			end
			nxt_st.oe[i] = en_own[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff.bus <= BUS_IDLE;
			st_ff.rdata <= 32'h0000_0000;
			st_ff.code <= {RST_CODE, RST_CODE};
			st_ff.ctl <= RST_CONTROL[7:5];
			st_ff.retain <= RST_STANDBY_CTRL[BIT_RETAIN_EN];
			st_ff.soft_d <= 1'b0;
			st_ff.run <= 2'b00;
			st_ff.cnt <= '0;
			st_ff.pend <= 2'b00;
			st_ff.level <= {RST_CODE, RST_CODE};
			st_ff.oe <= 2'b00;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// level shown whether or not the pin drives; code/256 of reference is analog side
	assign analog_out_ch0_o = st_ff.level[0];
	assign analog_out_ch1_o = st_ff.level[1];
	assign pin_oe_o = st_ff.oe;
	assign convert_run_o = st_ff.run;
	assign pending_o = st_ff.pend;
	assign avs_readdata_o = st_ff.rdata;
	assign avs_waitrequest_o = (st_ff.bus != BUS_ACK);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	no_conv_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_ff.ctl[2:1] == 2'b00) |-> (convert_run_o == 2'b00))
		else $error("conversion runs with both output enables clear");
	joint_run_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_ff.ctl == 3'b011 && !soft_standby_i && !hard_standby_i && !$past(hard_standby_i) && !$past(soft_standby_i)
		&& $past(st_ff.ctl) == 3'b011) |-> (convert_run_o == 2'b11))
		else $error("joint enable did not run both converters");
	pin_own_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(pin_oe_o[1] |-> st_ff.ctl[2]) and (pin_oe_o[0] |-> st_ff.ctl[1]))
		else $error("pin driven without its own output enable");
	rsvd_ctl_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && $past(avs_address_i) == OFS_CONTROL && $past(avs_read_i))
		|-> (avs_readdata_o[4:0] == 5'h1F))
		else $error("control reserved bits not read as one");
	rsvd_sby_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && $past(avs_address_i) == OFS_STANDBY_CTRL && $past(avs_read_i))
		|-> (avs_readdata_o[7:1] == 7'h7F))
		else $error("standby reserved bits not read as one");
	hard_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
		hard_standby_i |=> (st_ff.code == 16'h0000 && st_ff.retain == 1'b0 && pin_oe_o == 2'b00))
		else $error("hardware standby did not clear registers");
	retain_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(soft_standby_i && !st_ff.soft_d && st_ff.retain && !hard_standby_i && !avs_write_i)
		|=> (st_ff.code == $past(st_ff.code) && st_ff.ctl == $past(st_ff.ctl)))
		else $error("retained registers changed at standby entry");
	settle_time_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(pending_o[0] && !$past(pending_o[0])) |-> pending_o[0] [*8])
		else $error("conversion settled too early");
	pin_release_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(hard_standby_i || (soft_standby_i && !st_ff.retain)) |=> (pin_oe_o == 2'b00))
		else $error("pin still driven in standby");

	// ----------------------------------------------------------------
	// bus handshake checks
	// ----------------------------------------------------------------
	// one wait state always: a master that counts cycles still works
	ack_next_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(avs_waitrequest_o && (avs_read_i || avs_write_i)) |=> !avs_waitrequest_o)
		else $error("request not answered after one wait state");

	ack_single_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");

	rdata_upper_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!avs_waitrequest_o |-> (avs_readdata_o[31:8] == 24'h00_0000))
		else $error("read data upper lanes not zero");

	// ----------------------------------------------------------------
	// register write checks
	// ----------------------------------------------------------------
	// a standby clear in the same cycle beats the write, so it is excluded
	code0_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && avs_write_i && avs_byteenable_i[0] && avs_address_i == OFS_CODE_CH0
		&& !hard_standby_i && !(standby_entry && !keep_regs)) |=> (st_ff.code[0] == $past(avs_writedata_i[7:0])))
		else $error("channel 0 code write lost");

	code1_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && avs_write_i && avs_byteenable_i[0] && avs_address_i == OFS_CODE_CH1
		&& !hard_standby_i && !(standby_entry && !keep_regs)) |=> (st_ff.code[1] == $past(avs_writedata_i[7:0])))
		else $error("channel 1 code write lost");

	ctl_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && avs_write_i && avs_byteenable_i[0] && avs_address_i == OFS_CONTROL
		&& !hard_standby_i && !(standby_entry && !keep_regs)) |=> (st_ff.ctl == $past(avs_writedata_i[7:5])))
		else $error("control write lost");

	lane_refuse_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && avs_write_i && !avs_byteenable_i[0] && !hard_standby_i && !standby_entry)
		|=> ($stable(st_ff.code) && $stable(st_ff.ctl) && $stable(st_ff.retain)))
		else $error("write with lane 0 disabled changed a register");

	unmapped_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!avs_waitrequest_o && avs_write_i && !hard_standby_i && !standby_entry
		&& avs_address_i != OFS_CODE_CH0 && avs_address_i != OFS_CODE_CH1
		&& avs_address_i != OFS_CONTROL && avs_address_i != OFS_STANDBY_CTRL)
		|=> ($stable(st_ff.code) && $stable(st_ff.ctl) && $stable(st_ff.retain)))
		else $error("write to unmapped address changed a register");

	// ----------------------------------------------------------------
	// standby checks
	// ----------------------------------------------------------------
	hard_ctl_a: assert property (@(posedge clk_i) disable iff (srst_i)
		hard_standby_i |=> (st_ff.ctl == RST_CONTROL[7:5] && convert_run_o == 2'b00))
		else $error("hardware standby did not reset control");

	soft_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(standby_entry && !keep_regs) |=> (st_ff.code == 16'h0000 && st_ff.ctl == RST_CONTROL[7:5]))
		else $error("standby entry did not clear codes and control");

	// only a bus write or hardware standby may move the retain bit
	retain_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!hard_standby_i && !(!avs_waitrequest_o && avs_write_i)) |=> $stable(st_ff.retain))
		else $error("retain bit changed without a write");

	soft_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(soft_standby_i && st_ff.retain && !hard_standby_i) |=> (pin_oe_o == st_ff.ctl[2:1]))
		else $error("retained standby dropped the outputs");

	// ----------------------------------------------------------------
	// enable decode checks
	// ----------------------------------------------------------------
	pin_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!soft_standby_i && !hard_standby_i) |=> (pin_oe_o == st_ff.ctl[2:1]))
		else $error("pin drive does not follow its output enable");

	run_own_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!st_ff.ctl[0] |-> (convert_run_o == pin_oe_o))
		else $error("separate mode runs a converter without its enable");

	run_joint_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(st_ff.ctl[0] && pin_oe_o != 2'b00) |-> (convert_run_o == 2'b11))
		else $error("joint mode did not run both converters");

	run_none_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(pin_oe_o == 2'b00) |-> (convert_run_o == 2'b00))
		else $error("converter runs with no output enabled");

	chan_indep_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(!st_ff.ctl[0] && !pin_oe_o[1]) |-> !pending_o[1])
		else $error("channel 1 settles while it is off");

	pend0_run_a: assert property (@(posedge clk_i) disable iff (srst_i)
		pending_o[0] |-> convert_run_o[0])
		else $error("channel 0 pending without conversion");

	pend1_run_a: assert property (@(posedge clk_i) disable iff (srst_i)
		pending_o[1] |-> convert_run_o[1])
		else $error("channel 1 pending without conversion");

	// ----------------------------------------------------------------
	// conversion checks
	// ----------------------------------------------------------------
	start0_pend_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(convert_run_o[0]) |-> pending_o[0])
		else $error("channel 0 started without settling");

	start1_pend_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(convert_run_o[1]) |-> pending_o[1])
		else $error("channel 1 started without settling");

	restart0_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(convert_run_o[0] && !avs_waitrequest_o && avs_write_i && avs_byteenable_i[0]
		&& avs_address_i == OFS_CODE_CH0 && !soft_standby_i && !hard_standby_i) |=> pending_o[0])
		else $error("channel 0 code write did not restart conversion");

	restart1_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(convert_run_o[1] && !avs_waitrequest_o && avs_write_i && avs_byteenable_i[0]
		&& avs_address_i == OFS_CODE_CH1 && !soft_standby_i && !hard_standby_i) |=> pending_o[1])
		else $error("channel 1 code write did not restart conversion");

	settle1_time_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(pending_o[1] && !$past(pending_o[1])) |-> pending_o[1] [*8])
		else $error("channel 1 settled too early");

	// the level only moves when a settle completes, never mid-conversion
	level0_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$changed(analog_out_ch0_o) |-> $fell(pending_o[0]))
		else $error("channel 0 level changed outside a settle end");

	level1_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$changed(analog_out_ch1_o) |-> $fell(pending_o[1]))
		else $error("channel 1 level changed outside a settle end");

	level0_value_a: assert property (@(posedge clk_i) disable iff (srst_i)
		($fell(pending_o[0]) && convert_run_o[0]) |-> (analog_out_ch0_o == st_ff.code[0]))
		else $error("channel 0 settled to a wrong code");

	level1_value_a: assert property (@(posedge clk_i) disable iff (srst_i)
		($fell(pending_o[1]) && convert_run_o[1]) |-> (analog_out_ch1_o == st_ff.code[1]))
		else $error("channel 1 settled to a wrong code");
endmodule

`default_nettype wire

// *** core/dacc_pkg.sv ***
/*
 * Package for the two-channel eight-bit converter control block: register
 * offsets, reset values, field positions and settling timing.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package dacc_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses, one byte register each)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 20;
	localparam logic [19:0] OFS_CODE_CH0 = 20'hFFF9C;
	localparam logic [19:0] OFS_CODE_CH1 = 20'hFFF9D;
	localparam logic [19:0] OFS_CONTROL = 20'hFFF9E;
	localparam logic [19:0] OFS_STANDBY_CTRL = 20'hEE01A;
	// ----------------------------------------------------------------
	// reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CODE = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h1F;
	localparam logic [7:0] RST_STANDBY_CTRL = 8'hFE;
	localparam logic [7:0] CONTROL_RSVD_ONES = 8'h1F;
	localparam logic [7:0] STANDBY_RSVD_ONES = 8'hFE;
	localparam int unsigned BIT_OUT_EN_CH1 = 7;
	localparam int unsigned BIT_OUT_EN_CH0 = 6;
	localparam int unsigned BIT_JOINT_EN = 5;
	localparam int unsigned BIT_RETAIN_EN = 0;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CONV_TIME_NS = 10000;
	// longest time rounds down
	localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;
endpackage

// *** testbench/testbench.sv ***
/*
 * Self-checking bench for the converter control block: register reset values, enable table,
 * settle timing, standby retention, bus refusals and reset after a code write with conversion stopped.
 * Assumes the design answers every bus request through waitrequest and that CONV_CYC is set here.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import dacc_pkg::*;
	localparam int unsigned CONV = 10;
	// ----------------------------------------------------------------
	// rows: control write, readback, pin drive, converter run
	// ----------------------------------------------------------------
	localparam logic [19:0] ROWS [8] = '{20'h405F5, 20'h809FA, 20'h607F7, 20'hA0BFB,
		20'hC0DFF, 20'hE0FFF, 20'h203F0, 20'h001F0};
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic soft_standby_i = 1'b0;
	logic hard_standby_i = 1'b0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic [31:0] avs_writedata_i = '0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [7:0] analog_out_ch0_o;
	logic [7:0] analog_out_ch1_o;
	logic [1:0] pin_oe_o;
	logic [1:0] convert_run_o;
	logic [1:0] pending_o;
	int fail_count = 0;
	int check_count = 0;
	dacc_top #(.CONV_CYC(CONV)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .soft_standby_i(soft_standby_i),
		.hard_standby_i(hard_standby_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_address_i(avs_address_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.analog_out_ch0_o(analog_out_ch0_o), .analog_out_ch1_o(analog_out_ch1_o), .pin_oe_o(pin_oe_o),
		.convert_run_o(convert_run_o), .pending_o(pending_o));
	always #50 clk_i = ~clk_i;
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// entered just after a rising edge; an idle edge follows each request
	task automatic bus(input logic wr, input logic [19:0] a, input logic [7:0] d, input logic [3:0] be,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_address_i <= a;
		avs_writedata_i <= {24'h000000, d};
		avs_byteenable_i <= be;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		if (n >= 50) check(32'h0BAD0BAD, 32'h00000000);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rd(input logic [19:0] a, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		check(q, {24'h000000, exp});
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		fail_count++;
		test_done();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		cycles(6);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CODE_CH0, 8'h00);
		rd(OFS_CODE_CH1, 8'h00);
		rd(OFS_CONTROL, 8'h1F);
		rd(OFS_STANDBY_CTRL, 8'hFE);
		check(pin_oe_o, 2'b00);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_CONTROL, ROWS[i][19:12]);
			cycles(2);
			rd(OFS_CONTROL, ROWS[i][11:4]);
			check({pin_oe_o, convert_run_o}, ROWS[i][3:0]);
		end
		wr(OFS_CODE_CH0, 8'h5A);
		rd(OFS_CODE_CH0, 8'h5A);
		wr(OFS_CONTROL, 8'h40);
		@(posedge clk_i);
		check(pending_o, 2'b01);
		cycles(CONV + 4);
		check({pending_o, analog_out_ch0_o}, 10'h05A);
		wr(OFS_CODE_CH0, 8'hA5);
		@(posedge clk_i);
		check({pending_o, analog_out_ch0_o}, 10'h15A);
		wr(OFS_CONTROL, 8'hC0);
		wr(OFS_CODE_CH1, 8'h3C);
		cycles(CONV + 4);
		check({analog_out_ch1_o, analog_out_ch0_o}, 16'h3CA5);
		soft_standby_i <= 1'b1;
		cycles(3);
		check(pin_oe_o, 2'b00);
		soft_standby_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CODE_CH0, 8'h00);
		rd(OFS_CODE_CH1, 8'h00);
		rd(OFS_CONTROL, 8'h1F);
		wr(OFS_STANDBY_CTRL, 8'h01);
		rd(OFS_STANDBY_CTRL, 8'hFF);
		wr(OFS_CODE_CH0, 8'h77);
		wr(OFS_CONTROL, 8'hC0);
		soft_standby_i <= 1'b1;
		cycles(3);
		check(pin_oe_o, 2'b11);
		soft_standby_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CODE_CH0, 8'h77);
		rd(OFS_CONTROL, 8'hDF);
		rd(OFS_STANDBY_CTRL, 8'hFF);
		// refused accesses: lane 0 disabled, then an unmapped address
		bus(1'b1, OFS_CODE_CH0, 8'hFF, 4'hE, q);
		rd(OFS_CODE_CH0, 8'h77);
		wr(20'h00000, 8'h12);
		rd(20'h00000, 8'h00);
		hard_standby_i <= 1'b1;
		cycles(2);
		hard_standby_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_STANDBY_CTRL, 8'hFE);
		wr(OFS_CODE_CH1, 8'h99);
		srst_i <= 1'b1;
		cycles(2);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CODE_CH1, 8'h00);
		rd(OFS_CONTROL, 8'h1F);
		test_done();
	end
endmodule
`default_nettype wire
